//--- hw/adcs_consts.vh
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH

// ****************************************************************
// Conversion timing in converter clock cycles, result coding and sample count limit
// ****************************************************************
`define ADCS_BASE_CYCLES      6'd13
`define ADCS_HOLD_OFFSET      6'd2
`define ADCS_RES_BITS         10
`define ADCS_MAX_CODE         10'h3FF
`define ADCS_MSB_TRIAL        10'h200
`define ADCS_MAX_ACC_LOG2     3'd6

// ****************************************************************
// Selection encodings
// ****************************************************************
`define ADCS_REF_INTERNAL     2'h0
`define ADCS_TEMP_CHANNEL     5'h1E

// ****************************************************************
// Window compare modes
// ****************************************************************
`define ADCS_WIN_OFF          3'h0
`define ADCS_WIN_BELOW        3'h1
`define ADCS_WIN_ABOVE        3'h2
`define ADCS_WIN_INSIDE       3'h3
`define ADCS_WIN_OUTSIDE      3'h4

`endif

//--- hw/adcs_prescaler.v
`timescale 1ns/1ps
`include "adcs_consts.vh"

module adcs_prescaler
(
	input  wire       clk,
	input  wire       rst,
	input  wire       run,
	input  wire [2:0] div_sel,
	output wire       rise_tick
);

	reg  [7:0] cnt_r;
	wire [7:0] half;
	wire [7:0] last;

	// Factor is 2 << div_sel, rising edge in the middle of each period
	assign half = 8'h01 << div_sel;
	assign last = {half[6:0], 1'b0} - 8'h01;
	// Edge at count half: first edge half a factor plus one after the write
	assign rise_tick = run && (cnt_r == half);

	always @(posedge clk)
	begin
		if (rst || !run)
			cnt_r <= 8'h00;
		else if (cnt_r == last)
			cnt_r <= 8'h00;
		else
			cnt_r <= cnt_r + 8'h01;
	end

endmodule

//--- hw/adcs_sequencer.v
`timescale 1ns/1ps
`include "adcs_consts.vh"

module adcs_sequencer
(
	input  wire        REF_CLK,
	input  wire        RST,
	input  wire        ENABLE,
	input  wire [2:0]  CLK_DIV_SEL,
	input  wire        START_CONV_WR,
	input  wire        FREE_RUN,
	input  wire        EVENT_START_EN,
	input  wire        EVENT_IN,
	input  wire [3:0]  SAMPLE_DELAY,
	input  wire [4:0]  SAMPLE_LENGTH,
	input  wire [2:0]  SAMPLE_NUM,
	input  wire [4:0]  INPUT_CHANNEL_SEL,
	input  wire [1:0]  REFERENCE_SEL,
	input  wire [2:0]  WINDOW_COMPARE_MODE,
	input  wire [15:0] WINDOW_LOW_THRESHOLD,
	input  wire [15:0] WINDOW_HIGH_THRESHOLD,
	input  wire        WINDOW_HIT_IRQ_EN,
	input  wire        RESULT_READ,
	input  wire        RESULT_READY_CLR,
	input  wire        WINDOW_HIT_CLR,
	input  wire        ADC_CMP,
	output wire        START_CONV,
	output wire [4:0]  ACTIVE_CHANNEL,
	output wire [1:0]  ACTIVE_REFERENCE,
	output wire        REF_USE_INTERNAL,
	output wire        TEMP_SENSOR_ON,
	output wire        CONV_CLK_TICK,
	output wire        SAMPLE_HOLD,
	output wire [9:0]  SAR_TRIAL,
	output wire [15:0] CONV_RESULT,
	output wire        RESULT_READY,
	output wire        WINDOW_HIT,
	output wire        WINDOW_IRQ
);

	// ****************************************************************
	// State
	// ****************************************************************
	reg        start_conv_r;
	reg        event_prev_r;
	reg        locked_r;
	reg [5:0]  ccnt_r;
	reg [9:0]  sar_r;
	reg [9:0]  mask_r;
	reg [15:0] acc_r;
	reg [6:0]  scnt_r;
	reg [15:0] result_r;
	reg        result_ready_r;
	reg        window_hit_r;
	reg [4:0]  chan_r;
	reg [1:0]  ref_r;
	reg        hold_r;

	wire       run;
	wire       tick;
	wire       event_edge;
	wire [5:0] cur;
	wire [5:0] hold_at;
	wire [5:0] last_at;
	wire       bit_step;
	wire       sample_done;
	wire [9:0] sar_nxt;
	wire [9:0] mask_nxt;
	wire [15:0] acc_nxt;
	wire [2:0] acc_log2;
	wire [6:0] samples;
	wire       last_sample;
	wire       conv_done;
	wire       restart;
	reg        win_cond;

	// ****************************************************************
	// Converter clock
	// ****************************************************************
	assign run = start_conv_r && ENABLE;

	adcs_prescaler u_clk_div_sel
	(
		.clk       (REF_CLK),
		.rst       (RST),
		.run       (run),
		.div_sel   (CLK_DIV_SEL),
		.rise_tick (tick)
	);


	// ****************************************************************
	// Start requests
	// ****************************************************************
	// Previous level resets low, the idle level of the event line
	assign event_edge = EVENT_START_EN && EVENT_IN && !event_prev_r;

	always @(posedge REF_CLK)
	begin
		if (RST)
			event_prev_r <= 1'b0;
		else
			event_prev_r <= EVENT_IN;
	end

	// ****************************************************************
	// Conversion sequencing
	// ****************************************************************
	// Cycle index of this tick; first tick of a conversion is cycle 0
	assign cur = locked_r ? ccnt_r : 6'd0;
	assign hold_at = `ADCS_HOLD_OFFSET + {2'b00, SAMPLE_DELAY}
		+ {1'b0, SAMPLE_LENGTH};
	assign last_at = hold_at + 6'd`ADCS_RES_BITS;
	assign bit_step = tick && (cur > hold_at) && (cur <= last_at);
	assign sample_done = tick && (cur == last_at);

	// Keep the trial bit when input is at or above the trial level
	assign sar_nxt = (ADC_CMP ? sar_r : (sar_r & ~mask_r))
		| (mask_r >> 1);
	assign mask_nxt = mask_r >> 1;

	assign acc_log2 = (SAMPLE_NUM > `ADCS_MAX_ACC_LOG2) ? `ADCS_MAX_ACC_LOG2 : SAMPLE_NUM;
	assign samples = 7'h01 << acc_log2;
	assign last_sample = (scnt_r == samples - 7'h01);
	assign acc_nxt = acc_r + {6'h00, sar_nxt};
	assign conv_done = sample_done && last_sample;
	assign restart = FREE_RUN;

	always @(posedge REF_CLK)
	begin
		if (RST || !ENABLE)
		begin
			locked_r <= 1'b0;
			ccnt_r <= 6'd0;
			sar_r <= 10'h000;
			mask_r <= 10'h000;
			acc_r <= 16'h0000;
			scnt_r <= 7'h00;
			hold_r <= 1'b0;
		end
		else
		begin
			hold_r <= 1'b0;
			if (tick)
			begin
				locked_r <= 1'b1;
				ccnt_r <= cur + 6'd1;
				if (cur == hold_at)
				begin
					hold_r <= 1'b1;
					sar_r <= `ADCS_MSB_TRIAL;
					mask_r <= `ADCS_MSB_TRIAL;
				end
				else if (bit_step)
				begin
					sar_r <= sar_nxt;
					mask_r <= mask_nxt;
				end
				if (sample_done)
				begin
					ccnt_r <= 6'd0;
					if (last_sample)
					begin
						locked_r <= 1'b0;
						acc_r <= 16'h0000;
						scnt_r <= 7'h00;
					end
					else
					begin
						acc_r <= acc_nxt;
						scnt_r <= scnt_r + 7'h01;
					end
				end
			end
		end
	end

	// Start bit: set by write or event, held through the conversion
	always @(posedge REF_CLK)
	begin
		if (RST || !ENABLE)
			start_conv_r <= 1'b0;
		else if (START_CONV_WR || event_edge)
			start_conv_r <= 1'b1;
		else if (conv_done && !restart)
			start_conv_r <= 1'b0;
	end

	// ****************************************************************
	// Channel and reference buffering
	// ****************************************************************
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			chan_r <= 5'h00;
			ref_r <= `ADCS_REF_INTERNAL;
		end
		// Also copies in the final cycle, ready for a free-running restart
		else if (!locked_r || sample_done && last_sample)
		begin
			chan_r <= INPUT_CHANNEL_SEL;
			ref_r <= REFERENCE_SEL;
		end
	end

	// ****************************************************************
	// Window compare
	// ****************************************************************
	// Sum as it will be stored, so the compare needs no extra cycle
	always @*
	begin
		case (WINDOW_COMPARE_MODE)
			`ADCS_WIN_BELOW:
				win_cond = acc_nxt < WINDOW_LOW_THRESHOLD;
			`ADCS_WIN_ABOVE:
				win_cond = acc_nxt > WINDOW_HIGH_THRESHOLD;
			`ADCS_WIN_INSIDE:
				win_cond = (acc_nxt > WINDOW_LOW_THRESHOLD)
					&& (acc_nxt < WINDOW_HIGH_THRESHOLD);
			`ADCS_WIN_OUTSIDE:
				win_cond = (acc_nxt < WINDOW_LOW_THRESHOLD)
					|| (acc_nxt > WINDOW_HIGH_THRESHOLD);
			default:
				win_cond = 1'b0;
		endcase
	end

	// ****************************************************************
	// Result and flags
	// ****************************************************************
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			result_r <= 16'h0000;
			result_ready_r <= 1'b0;
			window_hit_r <= 1'b0;
		end
		else
		begin
			// Set wins over a clear in the same cycle
			if (conv_done)
			begin
				result_r <= acc_nxt;
				result_ready_r <= 1'b1;
			end
			else if (RESULT_READ || RESULT_READY_CLR)
				result_ready_r <= 1'b0;
			if (conv_done && win_cond)
				window_hit_r <= 1'b1;
			else if (WINDOW_HIT_CLR)
				window_hit_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign START_CONV = start_conv_r;
	assign ACTIVE_CHANNEL = chan_r;
	assign ACTIVE_REFERENCE = ref_r;
	assign REF_USE_INTERNAL = (ref_r == `ADCS_REF_INTERNAL);
	assign TEMP_SENSOR_ON = (chan_r == `ADCS_TEMP_CHANNEL);
	assign CONV_CLK_TICK = tick;
	assign SAMPLE_HOLD = hold_r;
	assign SAR_TRIAL = sar_r;
	assign CONV_RESULT = result_r;
	assign RESULT_READY = result_ready_r;
	assign WINDOW_HIT = window_hit_r;
	assign WINDOW_IRQ = window_hit_r && WINDOW_HIT_IRQ_EN;

endmodule

//--- tb/adcs_analog_model.sv
`timescale 1ns/1ps
module adcs_analog_model
(
	input  logic [4:0] channel,
	input  logic [9:0] trial,
	output logic       cmp
);
	// Channel n sits at code n*32+5; top channel exceeds the reference
	assign cmp = (channel == 5'h1F) || ({channel, 5'h05} >= trial);
endmodule

//--- tb/adcs_properties.sv
`timescale 1ns/1ps
module adcs_properties
(
	input logic       REF_CLK,
	input logic       RST,
	input logic       ENABLE,
	input logic [2:0] CLK_DIV_SEL,
	input logic       START_CONV_WR,
	input logic       FREE_RUN,
	input logic [3:0] SAMPLE_DELAY,
	input logic [4:0] SAMPLE_LENGTH,
	input logic       RESULT_READ,
	input logic       RESULT_READY_CLR,
	input logic       WINDOW_HIT_IRQ_EN,
	input logic       START_CONV,
	input logic       CONV_CLK_TICK,
	input logic       SAMPLE_HOLD,
	input logic       RESULT_READY,
	input logic       WINDOW_HIT,
	input logic       WINDOW_IRQ
);
	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// Divide by 32 single conversion, no added sampling
	wire plain = CLK_DIV_SEL == 3'h4 && !FREE_RUN
		&& SAMPLE_DELAY == 4'h0 && SAMPLE_LENGTH == 5'h00;
	property p_off_tick; !ENABLE |-> !CONV_CLK_TICK; endproperty
	a_off_tick: assert property (p_off_tick) else $error("tick while off");
	property p_idle_tick; !START_CONV |-> !CONV_CLK_TICK; endproperty
	a_idle_tick: assert property (p_idle_tick) else $error("tick while idle");
	property p_first; $rose(START_CONV) && plain |-> ##16 CONV_CLK_TICK; endproperty
	a_first: assert property (p_first) else $error("start delay");
	property p_start; START_CONV_WR && ENABLE && !START_CONV |=> START_CONV; endproperty
	a_start: assert property (p_start) else $error("start lost");
	property p_hold; $rose(START_CONV) && plain |-> ##81 SAMPLE_HOLD; endproperty
	a_hold: assert property (p_hold) else $error("hold time");
	property p_len; $rose(START_CONV) && plain |-> ##300 START_CONV
		##100 START_CONV ##1 !START_CONV;
	endproperty
	a_len: assert property (p_len) else $error("length");
	property p_keep; RESULT_READY && !RESULT_READ && !RESULT_READY_CLR |=> RESULT_READY; endproperty
	a_keep: assert property (p_keep) else $error("ready lost");
	property p_clear; (RESULT_READ || RESULT_READY_CLR) && !START_CONV |=> !RESULT_READY; endproperty
	a_clear: assert property (p_clear) else $error("ready stuck");
	property p_done; $fell(START_CONV) && $past(ENABLE) |-> RESULT_READY; endproperty
	a_done: assert property (p_done) else $error("end without ready");
	property p_irq; WINDOW_IRQ == (WINDOW_HIT && WINDOW_HIT_IRQ_EN); endproperty
	a_irq: assert property (p_irq) else $error("irq");
endmodule

//--- tb/adcs_sequencer_tb.sv
`timescale 1ns/1ps
module adcs_sequencer_tb;
	logic        clk, rst, en, wr, fr, ev_en, ev, rd, rclr, wclr, ien;
	logic [2:0]  div, num, mode;
	logic [3:0]  dly;
	logic [4:0]  len, ch;
	logic [1:0]  rsel;
	logic [15:0] lo, hi;
	wire         cmp, sc, iref, ton, rdy, hit, irq;
	wire [4:0]   ach;
	wire [1:0]   aref;
	wire [9:0]   trial;
	wire [15:0]  res;
	int          failures, comparisons, cyc, n, f;

	adcs_sequencer adcs_sequencer_i
	(
		.REF_CLK(clk), .RST(rst), .ENABLE(en), .CLK_DIV_SEL(div), .START_CONV_WR(wr),
		.FREE_RUN(fr), .EVENT_START_EN(ev_en), .EVENT_IN(ev), .SAMPLE_DELAY(dly),
		.SAMPLE_LENGTH(len), .SAMPLE_NUM(num), .INPUT_CHANNEL_SEL(ch), .REFERENCE_SEL(rsel),
		.WINDOW_COMPARE_MODE(mode), .WINDOW_LOW_THRESHOLD(lo), .WINDOW_HIGH_THRESHOLD(hi),
		.WINDOW_HIT_IRQ_EN(ien), .RESULT_READ(rd), .RESULT_READY_CLR(rclr),
		.WINDOW_HIT_CLR(wclr), .ADC_CMP(cmp), .START_CONV(sc), .ACTIVE_CHANNEL(ach),
		.ACTIVE_REFERENCE(aref), .REF_USE_INTERNAL(iref), .TEMP_SENSOR_ON(ton),
		.CONV_CLK_TICK(), .SAMPLE_HOLD(), .SAR_TRIAL(trial), .CONV_RESULT(res),
		.RESULT_READY(rdy), .WINDOW_HIT(hit), .WINDOW_IRQ(irq)
	);
	adcs_analog_model adcs_analog_model_i (.channel(ach), .trial(trial), .cmp(cmp));

	// ****************************************************************
	// Clock, timeout and access tasks
	// ****************************************************************
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			failures++;
			complete_run;
		end
	end
	task step;
		@(posedge clk);
		#1;
	endtask
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task complete_run;
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step;
		s = 0;
	endtask
	task wait_ready;
		n = 0;
		while (rdy !== 1'b1 && n < 9000)
		begin
			step;
			n++;
		end
		check("done", 16'(rdy), 16'h0001);
	endtask
	// Channel set one edge ahead of the start write
	task conv(input logic [4:0] c);
		ch = c;
		pulse(rd);
		check("readclr", 16'(rdy), 16'h0000);
		pulse(wr);
		wait_ready;
	endtask
	function logic [15:0] val(input logic [4:0] c);
		val = (c == 5'h1F) ? 16'h03FF : {6'h00, c, 5'h05};
	endfunction
	function logic win(input logic [2:0] m, input logic [15:0] v);
		case (m)
			3'h1: win = v < lo;
			3'h2: win = v > hi;
			3'h3: win = v > lo && v < hi;
			3'h4: win = v < lo || v > hi;
			default: win = 0;
		endcase
	endfunction

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial
	begin
		{rst, en, wr, fr, ev_en, ev, rd, rclr, wclr, ien} = '0;
		{div, num, mode, dly, len, ch, rsel, lo, hi} = '0;
		rst = 1;
		repeat (16) step;
		rst = 0;
		en = 1;
		for (int k = 0; k < 4; k++)
		begin
			div = 3'(k + 4);
			dly = 4'(k);
			len = 5'(2 * k);
			f = 2 << div;
			conv(5'(3 * k + 12));
			check("cycles", 16'(n), 16'(f / 2 + (12 + 3 * k) * f + 1));
			check("result", res, val(5'(3 * k + 12)));
			check("busy", 16'(sc), 16'h0000);
			pulse(rclr);
			check("ready", 16'(rdy), 16'h0000);
		end
		rsel = 2'h1;
		conv(5'h1F);
		check("sat", res, 16'h03FF);
		check("supply", 16'(iref), 16'h0000);
		check("reference_sel", 16'(aref), 16'h0001);
		rsel = 2'h0;
		len = 5'h05;
		conv(5'h1E);
		check("temp", 16'(ton), 16'h0001);
		check("intref", 16'(iref), 16'h0001);
		div = 3'h4;
		dly = 4'h0;
		len = 5'h00;
		fr = 1;
		ch = 5'h02;
		pulse(rd);
		pulse(wr);
		repeat (40) step;
		ch = 5'h03;
		wait_ready;
		check("frozen", res, val(5'h02));
		pulse(rclr);
		wait_ready;
		check("period", 16'(n + 1), 16'h01A0);
		check("next", res, val(5'h03));
		check("run", 16'(sc), 16'h0001);
		fr = 0;
		pulse(rclr);
		wait_ready;
		check("stop", 16'(sc), 16'h0000);
		pulse(rd);
		ev = 1;
		repeat (3) step;
		check("ignored", 16'(sc), 16'h0000);
		ev = 0;
		ev_en = 1;
		step;
		ev = 1;
		repeat (3) step;
		check("event", 16'(sc), 16'h0001);
		wait_ready;
		repeat (3) step;
		check("edge", 16'(sc), 16'h0000);
		ev = 0;
		ev_en = 0;
		for (int k = 0; k < 10; k++)
		begin
			mode = 3'(k % 5);
			lo = (k < 5) ? 16'h0085 : 16'h0086;
			hi = (k < 5) ? 16'h0085 : 16'h0084;
			ien = k[0];
			conv(5'h04);
			check("hit", 16'(hit), 16'(win(mode, 16'h0085)));
			check("irq", 16'(irq), 16'(win(mode, 16'h0085) & ien));
			pulse(wclr);
			check("hitclr", 16'(hit), 16'h0000);
		end
		num = 3'h2;
		dly = 4'h1;
		mode = 3'h1;
		lo = 16'h0200;
		conv(5'h04);
		check("sum", res, 16'h0214);
		check("late", 16'(hit), 16'h0000);
		pulse(wr);
		repeat (50) step;
		en = 0;
		repeat (2) step;
		check("abort", 16'(sc), 16'h0000);
		complete_run;
	end
endmodule

bind adcs_sequencer adcs_properties adcs_properties_i
(
	.REF_CLK, .RST, .ENABLE, .CLK_DIV_SEL, .START_CONV_WR, .FREE_RUN, .SAMPLE_DELAY,
	.SAMPLE_LENGTH, .RESULT_READ, .RESULT_READY_CLR, .WINDOW_HIT_IRQ_EN, .START_CONV,
	.CONV_CLK_TICK, .SAMPLE_HOLD, .RESULT_READY, .WINDOW_HIT, .WINDOW_IRQ
);
